//--- hw/tcp_channel.sv
// Function
// [RL1] Enable high requests access, low idles
// [RL2] Write qualifier: low read, high write
// [RL3] Write request lasts exactly one cycle
// [RL4] Ready pulse marks write completion
// [RL5] Read data valid with ready pulse
// [RL6] Read data bus is 16 bits
// [RL7] 16-bit write data, 10-bit address
// [RL8] No new request until ready pulses; after a timeout the controller may request again without a ready pulse
`timescale 1ns/100ps
`default_nettype none

`include "tcp_defines.svh"

module tcp_channel
    import tcp_pkg::*;
#(
    parameter int LATENCY = `TCP_LATENCY
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    tcp_if.device port_in
);

    // ------------------------------------------------------------------------
    // Derived constants
    // ------------------------------------------------------------------------
    // A latency below one would wrap the countdown to all ones, so the load
    // value is held at zero there; latencies beyond the counter's reach are
    // cut to its width, which the user must keep in mind.
    localparam int LOAD = (LATENCY > 1) ? LATENCY - 1 : 0;
    localparam logic [`TCP_CNT_W-1:0] CNT_LOAD = `TCP_CNT_W'(LOAD);

    // ------------------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------------------
    // Contents survive reset on purpose, as configuration cells usually do.
    // A word reads as unknown until it is first written, so a controller
    // should write a location before it reads it back.
    tcp_data_type mem [`TCP_DEPTH];

    // ------------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------------
    tcp_state_type state;
    tcp_state_type next_state;
    logic [`TCP_CNT_W-1:0] cnt;
    logic [`TCP_CNT_W-1:0] next_cnt;
    logic take;
    logic finish;

    // [RL1] take a request
    assign take = (state == TCP_IDLE) && port_in.en;
    // The last busy cycle, in which the access completes.
    assign finish = (state == TCP_BUSY) && (cnt == '0);

    // Only one access is in flight; a request that arrives while busy is
    // dropped rather than queued, which keeps the channel free of buffers.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            TCP_IDLE: begin
                if (take) begin
                    next_cnt = CNT_LOAD;
                    next_state = TCP_BUSY;
                end
            end
            TCP_BUSY: begin
                // Requests seen while busy are ignored; the controller must wait.
                if (finish) begin
                    next_state = TCP_IDLE;
                end else begin
                    next_cnt = cnt - `TCP_CNT_W'(1);
                end
            end
            default: begin
                next_state = TCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state <= TCP_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------------------
    // Completion strobe
    // ------------------------------------------------------------------------
    logic rdy;
    logic next_rdy;

    // The strobe is registered so that it never glitches on the port and
    // stands for exactly one cycle, even with a request waiting behind it.
    always_comb begin
        next_rdy = 1'b0;
        // [RL4] signal completion
        if (finish) begin
            next_rdy = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdy <= 1'b0;
        end else begin
            rdy <= next_rdy;
        end
    end

    // ------------------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------------------
    logic write_pending;
    logic next_write_pending;
    tcp_addr_type addr;
    tcp_addr_type next_addr;
    tcp_data_type wdata;
    tcp_data_type next_wdata;

    // The request is sampled only at the taking edge, so the controller may
    // move its address and data as soon as the request has been taken.
    always_comb begin
        next_write_pending = write_pending;
        next_addr = addr;
        next_wdata = wdata;
        if (take) begin
            // [RL2] select access type
            next_write_pending = port_in.we;
            next_addr = port_in.addr;
            next_wdata = port_in.wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            write_pending <= 1'b0;
            addr <= '0;
            wdata <= '0;
        end else begin
            write_pending <= next_write_pending;
            addr <= next_addr;
            wdata <= next_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    tcp_data_type rdata;
    tcp_data_type next_rdata;

    // A write leaves the last read word on the bus, so a controller that
    // samples read data on every strobe never sees its own write data.
    always_comb begin
        next_rdata = rdata;
        // [RL5] present read data
        if (finish && !write_pending) begin
            next_rdata = mem[addr];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Storage write, committed as ready rises
    // ------------------------------------------------------------------------
    logic commit;

    assign commit = finish && write_pending;

    // One word of flip-flops per entry; only the addressed word loads, so the
    // cost is one comparator per entry instead of a shared write decoder.
    for (genvar entry = 0; entry < `TCP_DEPTH; entry++) begin : g_cell
        tcp_data_type next_word;

        always_comb begin
            next_word = mem[entry];
            if (commit && (addr == tcp_addr_type'(entry))) begin
                next_word = wdata;
            end
        end

        always_ff @(posedge ref_clk_in) begin
            mem[entry] <= next_word;
        end
    end

    // ------------------------------------------------------------------------
    // Port outputs
    // ------------------------------------------------------------------------
    // [RL6] 16-bit read data
    assign port_in.rdata = rdata;
    assign port_in.rdy = rdy;

endmodule // tcp_channel

`default_nettype wire

//--- hw/tcp_defines.svh
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and timing of the dynamic config port
// ----------------------------------------------------------------------------
`define TCP_ADDR_W 10
`define TCP_DATA_W 16
`define TCP_DEPTH 1024
`define TCP_LATENCY 2
`define TCP_CNT_W 4
`define TCP_MEM_RESET 16'h0000
`define TCP_TIMEOUT 8'h40

`endif

//--- hw/tcp_pkg.sv
package tcp_pkg;
    `include "tcp_defines.svh"

    typedef logic [`TCP_ADDR_W-1:0] tcp_addr_type;
    typedef logic [`TCP_DATA_W-1:0] tcp_data_type;

    typedef enum logic [1:0] {
        TCP_IDLE = 2'b00,
        TCP_BUSY = 2'b01,
        TCP_WAIT = 2'b10
    } tcp_state_type;
endpackage

//--- hw/tcp_if.sv
`timescale 1ns/100ps
`default_nettype none

interface tcp_if;
    import tcp_pkg::*;
    logic en;
    logic we;
    tcp_addr_type addr;
    tcp_data_type wdata;
    tcp_data_type rdata;
    logic rdy;

    modport device (input en, input we, input addr, input wdata, output rdata, output rdy);
    modport ctrl (output en, output we, output addr, output wdata, input rdata, input rdy);
endinterface // tcp_if

`default_nettype wire

//--- hw/tcp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

`include "tcp_defines.svh"

module tcp_ctrl
    import tcp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic req_write_in,
    input wire tcp_addr_type req_addr_in,
    input wire tcp_data_type req_wdata_in,
    output logic req_ready_out,
    output logic done_out,
    output logic timeout_out,
    output tcp_data_type rdata_out,
    tcp_if.ctrl port_out
);

    // ------------------------------------------------------------------------
    // One access at a time
    // ------------------------------------------------------------------------
    tcp_state_type state;
    tcp_state_type next_state;
    logic en;
    logic next_en;
    logic we;
    logic next_we;
    tcp_addr_type addr;
    tcp_addr_type next_addr;
    tcp_data_type wdata;
    tcp_data_type next_wdata;
    tcp_data_type rdata;
    tcp_data_type next_rdata;
    logic done;
    logic next_done;
    logic tmo;
    logic next_tmo;
    logic [7:0] wait_cnt;
    logic [7:0] next_wait_cnt;

    always_comb begin
        next_state = state;
        // [RL3] one-cycle request pulse
        next_en = 1'b0;
        next_we = 1'b0;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_done = 1'b0;
        next_tmo = 1'b0;
        next_wait_cnt = wait_cnt;
        case (state)
            TCP_IDLE: begin
                // [RL1] drive enable for a request
                if (req_in) begin
                    next_en = 1'b1;
                    // [RL2] qualifier sets the type
                    next_we = req_write_in;
                    // [RL7] address and write data
                    next_addr = req_addr_in;
                    next_wdata = req_wdata_in;
                    next_wait_cnt = '0;
                    next_state = TCP_WAIT;
                end
            end
            TCP_WAIT: begin
                // [RL8] hold off until ready or until wait_cnt reaches the timeout
                if (port_out.rdy) begin
                    next_rdata = port_out.rdata;
                    next_done = 1'b1;
                    next_state = TCP_IDLE;
                end else if (wait_cnt == `TCP_TIMEOUT) begin
                    // A dead channel must not hang the controller forever.
                    next_tmo = 1'b1;
                    next_state = TCP_IDLE;
                end else begin
                    next_wait_cnt = wait_cnt + 8'h01;
                end
            end
            default: begin
                next_state = TCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state <= TCP_IDLE;
            en <= 1'b0;
            we <= 1'b0;
            addr <= '0;
            wdata <= '0;
            rdata <= '0;
            done <= 1'b0;
            tmo <= 1'b0;
            wait_cnt <= '0;
        end else begin
            state <= next_state;
            en <= next_en;
            we <= next_we;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            done <= next_done;
            tmo <= next_tmo;
            wait_cnt <= next_wait_cnt;
        end
    end

    assign port_out.en = en;
    assign port_out.we = we;
    assign port_out.addr = addr;
    assign port_out.wdata = wdata;
    assign req_ready_out = (state == TCP_IDLE);
    assign done_out = done;
    assign timeout_out = tmo;
    assign rdata_out = rdata;

endmodule // tcp_ctrl

`default_nettype wire

//--- tb/tcp_checker.sv
`timescale 1ns/100ps
`default_nettype none

module tcp_checker
    import tcp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic en,
    input wire logic we,
    input wire tcp_addr_type addr,
    input wire tcp_data_type wdata,
    input wire tcp_data_type rdata,
    input wire logic rdy
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    req_answer_a: assert property (en |-> ##3 rdy) else $error("ready late");
    rdy_cause_a: assert property (rdy |-> $past(en, 3)) else $error("ready unasked");
    rdy_pulse_a: assert property (rdy |=> !rdy) else $error("ready too long");
    write_pulse_a: assert property (en && we |=> !we && !en) else $error("write too long");
    no_overlap_a: assert property (en |=> !en [*3]) else $error("request overlap");
    addr_hold_a: assert property (en |=> ($stable(addr) && $stable(wdata)) [*3]) else $error("addr moved");
    rdata_hold_a: assert property (!rdy |-> $stable(rdata)) else $error("data moved");
    write_keeps_a: assert property (rdy && $past(we, 3) |-> $stable(rdata)) else $error("write hit data");
endmodule // tcp_checker

`default_nettype wire

//--- tb/test_transceiver_config_port.sv
`timescale 1ns/100ps
`default_nettype none

module test_transceiver_config_port;
    import tcp_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_in = 1'b0;
    logic req_write_in = 1'b0;
    tcp_addr_type req_addr_in = '0;
    tcp_data_type req_wdata_in = '0;
    logic req_ready_out;
    logic done_out;
    logic timeout_out;
    tcp_data_type rdata_out;
    tcp_data_type last = '0;
    tcp_data_type mem [0:1023];
    tcp_data_type exp_q [$];
    tcp_addr_type adr [0:15];
    logic [15:0] seed = 16'h8A45;
    logic [15:0] r;
    int failures = 0;
    int checks_done = 0;

    tcp_if link();
    tcp_channel i_tcp_channel (.ref_clk_in, .rst_n_in, .port_in(link));
    tcp_ctrl i_tcp_ctrl (.ref_clk_in, .rst_n_in, .req_in, .req_write_in, .req_addr_in, .req_wdata_in,
        .req_ready_out, .done_out, .timeout_out, .rdata_out, .port_out(link));
    tcp_checker u_chk (.ref_clk_in, .rst_n_in, .en(link.en), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .rdy(link.rdy));

    always #2.5 ref_clk_in = ~ref_clk_in;

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction

    task automatic cmp_data(input tcp_data_type e, input tcp_data_type s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("wrong value rdata_out expected %h seen %h", e, s);
        end
    endtask

    task automatic cmp_flag(input string n, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %b seen %b", n, e, s);
        end
    endtask

    // Request stays up while the controller is busy, so refused requests are exercised too.
    task automatic op(input logic w, input tcp_addr_type a, input tcp_data_type d);
        req_in = 1'b1;
        req_write_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        while (req_ready_out !== 1'b1) @(posedge ref_clk_in) #1;
        if (w) mem[a] = d;
        else last = mem[a];
        exp_q.push_back(last);
        @(posedge ref_clk_in) #1;
        cmp_flag("req_ready_out", 1'b0, req_ready_out);
    endtask

    task automatic conclude();
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        #1;
        if (rst_n_in) cmp_flag("timeout_out", 1'b0, timeout_out);
        if (done_out === 1'b1) cmp_data(exp_q.pop_front(), rdata_out);
    end

    // Some 60 transfers of five cycles each need far less than this span.
    initial begin
        #20000;
        failures++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        op(1'b1, 10'h000, rnd());
        op(1'b1, 10'h3FF, rnd());
        op(1'b0, 10'h3FF, 16'h0000);
        op(1'b0, 10'h000, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            adr[i] = tcp_addr_type'(rnd());
            op(1'b1, adr[i], rnd());
        end
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            op(r[0], adr[r[4:1]], rnd());
            if (r[5]) begin
                req_in = 1'b0;
                repeat (3) @(posedge ref_clk_in) #1;
            end
        end
        req_in = 1'b0;
        repeat (10) @(posedge ref_clk_in);
        cmp_flag("pending_results", 1'b0, exp_q.size() != 0);
        conclude();
    end
endmodule // test_transceiver_config_port

`default_nettype wire
